// *** rtl/lpi_direction_ctl.sv ***
// one port's transmit and receive low power idle control
`timescale 1ns/1ps
`default_nettype none
module lpi_direction_ctl #(
  parameter int WAKE_CYCLES = pwr_mgr_pkg::WAKE_DELAY_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic eee_ok_i,
  input wire logic tx_lpi_req_i,
  input wire logic rx_lpi_ind_i,
  // outputs
  output logic tx_assert_lpi_o,
  output logic mac_tx_en_o,
  output logic tx_clk_gate_o,
  output logic rx_clk_gate_o
);
  initial begin
    if (WAKE_CYCLES < 1) $error("wake delay must be at least one cycle");
  end

  logic [15:0] wake_cnt_reg;
  logic lpi_req;

  // ************
  // tx direction
  // ************
  // no capability agreed means no request ever reaches the line
  assign lpi_req = tx_lpi_req_i & eee_ok_i;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_assert_lpi_o <= 1'b0;
    end else begin
      tx_assert_lpi_o <= lpi_req;
    end
  end

  // mac held off until the partner had time to wake, so no frame is cut
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wake_cnt_reg <= 16'h0000;
      mac_tx_en_o <= 1'b1;
    end else if (lpi_req) begin
      wake_cnt_reg <= 16'(WAKE_CYCLES);
      mac_tx_en_o <= 1'b0;
    end else if (wake_cnt_reg != 16'h0000) begin
      wake_cnt_reg <= wake_cnt_reg - 16'h0001;
      mac_tx_en_o <= (wake_cnt_reg == 16'h0001);
    end else begin
      mac_tx_en_o <= 1'b1;
    end
  end

  // ************
  // clock gating
  // ************
  // each direction gated on its own state only
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_clk_gate_o <= 1'b0;
      rx_clk_gate_o <= 1'b0;
    end else begin
      tx_clk_gate_o <= lpi_req;
      rx_clk_gate_o <= rx_lpi_ind_i & eee_ok_i;
    end
  end

  txblock_a: assert property (@(posedge clk_i) disable iff (rst_i)
    lpi_req |=> !mac_tx_en_o && tx_assert_lpi_o)
    else $error("mac not blocked during lpi");
  noeee_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !eee_ok_i |=> !tx_assert_lpi_o)
    else $error("lpi asserted without capability");
endmodule
`default_nettype wire

// *** rtl/pwr_mgr_pkg.sv ***
// constants shared by the switch power mode manager
package pwr_mgr_pkg;
  // register offsets
  localparam logic [7:0] OFF_POWER_MODE_CONTROL = 8'h0E;
  localparam logic [7:0] OFF_SLEEP_IDLE_TIMEOUT = 8'h0F;
  localparam logic [7:0] OFF_PORT_ONE_POWER = 8'h1D;
  localparam logic [7:0] OFF_PORT_TWO_POWER = 8'h2D;
  localparam logic [7:0] OFF_PORT_THREE_POWER = 8'h3D;
  // field positions
  localparam int MODE_LSB = 3;
  localparam int MODE_MSB = 4;
  localparam int PORT_PD_BIT = 3;
  localparam int PHY_CTL_PD_BIT = 11;
  // mode codes
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_ENERGY = 2'h1;
  localparam logic [1:0] MODE_SOFT_PD = 2'h2;
  localparam logic [1:0] MODE_RESERVED = 2'h3;
  // reset values
  localparam logic [7:0] RST_POWER_MODE = 8'h00;
  localparam logic [7:0] RST_SLEEP_IDLE = 8'h50;
  localparam logic [7:0] RST_PORT_POWER = 8'h00;
  // timing
  localparam int CLK_HZ = 10_000_000;
  localparam int CLK_PERIOD_NS = 100;
  localparam int PULSE_WIDTH_NS = 120;
  localparam int PULSE_CYCLES = (PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_PERIOD_MS = 1000;
  localparam int PULSE_PERIOD_CYCLES = PULSE_PERIOD_MS * (CLK_HZ / 1000);
  localparam int SLEEP_UNIT_MS = 1;
  localparam int SLEEP_UNIT_CYCLES = SLEEP_UNIT_MS * (CLK_HZ / 1000);
  localparam int WAKE_DELAY_NS = 1000;
  localparam int WAKE_DELAY_CYCLES = (WAKE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// *** rtl/switch_power_mode_manager.sv ***
// switch power mode manager: modes, sleep timer, port power-down, lpi
// What this block does
// - mode field decodes 00 normal, 01 energy detect, 10 soft down, 11 reserved
// - after power-up or hardware reset the mode field reads normal
// - host writes the mode field in normal mode to change mode
// - normal mode: clocks run, phys and macs powered, host access works
// - energy detect: no energy longer than go-sleep time enters low power
// - low power state keeps watching energy and wakes on energy
// - low power state disables all but the energy detector and the link pulse generator
// - energy detect mode emits link pulses once per second, 120 ns rounded up to two 100 ns cycles (200 ns)
// - cable traffic allowed only in the normal power state
// - soft power-down stops clocks and turns off all phys and macs
// - host access in soft power-down returns normal and resets registers
// - port power-down bit powers that phy down regardless of mode
// - phy control bit 11 also powers the port down
// - low power idle handled per direction independently
// - low power idle gates unused mac and switch clocks
// - lpi entry and exit keep link status and frames intact
// - lpi request sends assert encoding, blocks mac, re-enables after delay
// - lpi only when both ends advertised it
`timescale 1ns/1ps
`default_nettype none
module switch_power_mode_manager #(
  parameter int NUM_PORTS = 3,
  parameter int PULSE_PERIOD = pwr_mgr_pkg::PULSE_PERIOD_CYCLES,
  parameter int SLEEP_UNIT = pwr_mgr_pkg::SLEEP_UNIT_CYCLES
) (
  // clock and reset
  input wire logic CORE_CLK_I,
  input wire logic SYS_RST_I,
  // host register port
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  output logic [7:0] REG_RDATA_O,
  output logic REG_READY_O,
  // cable side
  input wire logic [NUM_PORTS-1:0] CABLE_ENERGY_I,
  input wire logic [NUM_PORTS*16-1:0] PHY_BASIC_CONTROL_I,
  input wire logic [NUM_PORTS-1:0] EEE_OK_I,
  input wire logic [NUM_PORTS-1:0] TX_LPI_REQ_I,
  input wire logic [NUM_PORTS-1:0] RX_LPI_IND_I,
  // power controls
  output logic PLL_EN_O,
  output logic MAC_EN_O,
  output logic HOST_IF_EN_O,
  output logic INT_RST_O,
  output logic PACKET_EN_O,
  output logic LINK_PULSE_O,
  output logic [NUM_PORTS-1:0] PHY_PWR_EN_O,
  output logic [NUM_PORTS-1:0] PHY_RX_ED_EN_O,
  output logic [NUM_PORTS-1:0] TX_ASSERT_LPI_O,
  output logic [NUM_PORTS-1:0] MAC_TX_EN_O,
  output logic [NUM_PORTS-1:0] TX_CLK_GATE_O,
  output logic [NUM_PORTS-1:0] RX_CLK_GATE_O
);
  initial begin
    if (NUM_PORTS != 3) $error("register map serves exactly three ports");
    if (PULSE_PERIOD <= pwr_mgr_pkg::PULSE_CYCLES) $error("pulse period too short");
    if (SLEEP_UNIT < 1) $error("sleep unit must be positive");
  end

  typedef enum {ST_NORMAL, ST_ED_AWAKE, ST_ED_SLEEP, ST_SOFT_PD} pstate_t;

  pstate_t state_reg;
  logic [7:0] mode_ctl_reg;
  logic [7:0] sleep_idle_reg;
  logic [7:0] port_pwr_reg [NUM_PORTS];
  logic [1:0] mode_cur;
  logic [1:0] mode_wr;
  logic any_access;
  logic wr_ok;
  logic wake_rst;
  logic any_energy;
  logic [23:0] unit_cnt_reg;
  logic [7:0] idle_cnt_reg;
  logic [31:0] pulse_cnt_reg;
  logic [NUM_PORTS-1:0] port_pd;
  logic [NUM_PORTS-1:0] mac_tx_raw;

  assign mode_cur = mode_ctl_reg[pwr_mgr_pkg::MODE_MSB:pwr_mgr_pkg::MODE_LSB];
  assign mode_wr = REG_WDATA_I[pwr_mgr_pkg::MODE_MSB:pwr_mgr_pkg::MODE_LSB];
  assign any_access = REG_WR_I | REG_RD_I;
  assign any_energy = |CABLE_ENERGY_I;
  // host interface is off in low power states; writes there are dropped, and an access wakes only from soft power-down
  assign wr_ok = REG_WR_I & (state_reg == ST_NORMAL || state_reg == ST_ED_AWAKE);
  assign wake_rst = any_access & (state_reg == ST_SOFT_PD);

  // ************
  // registers
  // ************
  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      mode_ctl_reg <= pwr_mgr_pkg::RST_POWER_MODE;
      sleep_idle_reg <= pwr_mgr_pkg::RST_SLEEP_IDLE;
      for (int i = 0; i < NUM_PORTS; i++) begin
        port_pwr_reg[i] <= pwr_mgr_pkg::RST_PORT_POWER;
      end
    end else if (wake_rst) begin
      mode_ctl_reg <= pwr_mgr_pkg::RST_POWER_MODE;
      sleep_idle_reg <= pwr_mgr_pkg::RST_SLEEP_IDLE;
      for (int i = 0; i < NUM_PORTS; i++) begin
        port_pwr_reg[i] <= pwr_mgr_pkg::RST_PORT_POWER;
      end
    end else if (wr_ok) begin
      unique case (REG_ADDR_I)
        pwr_mgr_pkg::OFF_POWER_MODE_CONTROL: begin
          // reserved code keeps the old field, other bits still stored
          if (mode_wr == pwr_mgr_pkg::MODE_RESERVED) begin
            mode_ctl_reg <= {REG_WDATA_I[7:5], mode_cur, REG_WDATA_I[2:0]};
          end else begin
            mode_ctl_reg <= REG_WDATA_I;
          end
        end
        pwr_mgr_pkg::OFF_SLEEP_IDLE_TIMEOUT: sleep_idle_reg <= REG_WDATA_I;
        pwr_mgr_pkg::OFF_PORT_ONE_POWER: port_pwr_reg[0] <= REG_WDATA_I;
        pwr_mgr_pkg::OFF_PORT_TWO_POWER: port_pwr_reg[1] <= REG_WDATA_I;
        pwr_mgr_pkg::OFF_PORT_THREE_POWER: port_pwr_reg[2] <= REG_WDATA_I;
        default: ;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      REG_RDATA_O <= 8'h00;
    end else if (REG_RD_I) begin
      unique case (REG_ADDR_I)
        pwr_mgr_pkg::OFF_POWER_MODE_CONTROL: REG_RDATA_O <= mode_ctl_reg;
        pwr_mgr_pkg::OFF_SLEEP_IDLE_TIMEOUT: REG_RDATA_O <= sleep_idle_reg;
        pwr_mgr_pkg::OFF_PORT_ONE_POWER: REG_RDATA_O <= port_pwr_reg[0];
        pwr_mgr_pkg::OFF_PORT_TWO_POWER: REG_RDATA_O <= port_pwr_reg[1];
        pwr_mgr_pkg::OFF_PORT_THREE_POWER: REG_RDATA_O <= port_pwr_reg[2];
        default: REG_RDATA_O <= 8'h00;
      endcase
    end
  end

  assign REG_READY_O = HOST_IF_EN_O;

  // ************
  // mode state machine
  // ************
  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      state_reg <= ST_NORMAL;
    end else begin
      unique case (state_reg)
        ST_NORMAL: begin
          if (mode_cur == pwr_mgr_pkg::MODE_ENERGY) state_reg <= ST_ED_AWAKE;
          else if (mode_cur == pwr_mgr_pkg::MODE_SOFT_PD) state_reg <= ST_SOFT_PD;
        end
        ST_ED_AWAKE: begin
          if (mode_cur != pwr_mgr_pkg::MODE_ENERGY) state_reg <= ST_NORMAL;
          else if (!any_energy && idle_cnt_reg > sleep_idle_reg) state_reg <= ST_ED_SLEEP;
        end
        ST_ED_SLEEP: begin
          if (any_energy) state_reg <= ST_ED_AWAKE;
        end
        ST_SOFT_PD: begin
          if (any_access) state_reg <= ST_NORMAL;
        end
      endcase
    end
  end

  // go-sleep timer counts idle units while no energy is seen
  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      unit_cnt_reg <= 24'h000000;
      idle_cnt_reg <= 8'h00;
    end else if (state_reg != ST_ED_AWAKE || any_energy) begin
      unit_cnt_reg <= 24'h000000;
      idle_cnt_reg <= 8'h00;
    end else if (unit_cnt_reg == 24'(SLEEP_UNIT - 1)) begin
      unit_cnt_reg <= 24'h000000;
      if (idle_cnt_reg != 8'hFF) idle_cnt_reg <= idle_cnt_reg + 8'h01;
    end else begin
      unit_cnt_reg <= unit_cnt_reg + 24'h000001;
    end
  end

  // link pulse generator: free period counter in energy detect mode
  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      pulse_cnt_reg <= 32'h00000000;
      LINK_PULSE_O <= 1'b0;
    end else if (state_reg != ST_ED_AWAKE && state_reg != ST_ED_SLEEP) begin
      pulse_cnt_reg <= 32'h00000000;
      LINK_PULSE_O <= 1'b0;
    end else begin
      if (pulse_cnt_reg == 32'(PULSE_PERIOD - 1)) pulse_cnt_reg <= 32'h00000000;
      else pulse_cnt_reg <= pulse_cnt_reg + 32'h00000001;
      LINK_PULSE_O <= (pulse_cnt_reg < 32'(pwr_mgr_pkg::PULSE_CYCLES));
    end
  end

  // ************
  // power outputs
  // ************
  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      PLL_EN_O <= 1'b1;
      MAC_EN_O <= 1'b1;
      HOST_IF_EN_O <= 1'b1;
      PACKET_EN_O <= 1'b1;
      INT_RST_O <= 1'b0;
    end else begin
      PLL_EN_O <= (state_reg == ST_NORMAL || state_reg == ST_ED_AWAKE);
      MAC_EN_O <= (state_reg == ST_NORMAL || state_reg == ST_ED_AWAKE);
      HOST_IF_EN_O <= (state_reg == ST_NORMAL || state_reg == ST_ED_AWAKE);
      PACKET_EN_O <= (state_reg == ST_NORMAL || state_reg == ST_ED_AWAKE);
      INT_RST_O <= wake_rst;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_PORTS; g++) begin : g_port
      assign port_pd[g] = port_pwr_reg[g][pwr_mgr_pkg::PORT_PD_BIT]
        | PHY_BASIC_CONTROL_I[g*16 + pwr_mgr_pkg::PHY_CTL_PD_BIT];

      always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
          PHY_PWR_EN_O[g] <= 1'b1;
          PHY_RX_ED_EN_O[g] <= 1'b1;
        end else begin
          PHY_PWR_EN_O[g] <= !port_pd[g] && (state_reg == ST_NORMAL
            || state_reg == ST_ED_AWAKE);
          PHY_RX_ED_EN_O[g] <= !port_pd[g] && state_reg != ST_SOFT_PD;
        end
      end

      lpi_direction_ctl lpi_direction_ctl_inst (
        .clk_i(CORE_CLK_I),
        .rst_i(SYS_RST_I),
        .eee_ok_i(EEE_OK_I[g]),
        .tx_lpi_req_i(TX_LPI_REQ_I[g]),
        .rx_lpi_ind_i(RX_LPI_IND_I[g]),
        .tx_assert_lpi_o(TX_ASSERT_LPI_O[g]),
        .mac_tx_en_o(mac_tx_raw[g]),
        .tx_clk_gate_o(TX_CLK_GATE_O[g]),
        .rx_clk_gate_o(RX_CLK_GATE_O[g])
      );
      // lpi never touches link status; mac just waits, frames held not dropped
      assign MAC_TX_EN_O[g] = mac_tx_raw[g];
    end
  endgenerate

  // ************
  // assertions
  // ************
  reserved_keep_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    wr_ok && !wake_rst && REG_ADDR_I == pwr_mgr_pkg::OFF_POWER_MODE_CONTROL
    && mode_wr == pwr_mgr_pkg::MODE_RESERVED |=> $stable(mode_cur))
    else $error("reserved mode code changed mode");
  mode_decode_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    state_reg == ST_NORMAL && mode_cur == pwr_mgr_pkg::MODE_SOFT_PD |=> state_reg == ST_SOFT_PD)
    else $error("soft power-down code not decoded");
  soft_off_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    state_reg == ST_SOFT_PD && !any_access |=> !PLL_EN_O && !MAC_EN_O && PHY_PWR_EN_O == '0)
    else $error("clocks or phys on in soft power-down");
  wake_reset_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    wake_rst |=> INT_RST_O && state_reg == ST_NORMAL
    && mode_ctl_reg == pwr_mgr_pkg::RST_POWER_MODE)
    else $error("host access did not wake and reset");
  sleep_wake_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    state_reg == ST_ED_SLEEP && any_energy |=> state_reg == ST_ED_AWAKE ##1 PLL_EN_O)
    else $error("energy did not wake device");
  sleep_off_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    state_reg == ST_ED_SLEEP |=> !PACKET_EN_O && !HOST_IF_EN_O)
    else $error("circuits alive in low power state");
  go_sleep_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    state_reg == ST_ED_SLEEP && $past(state_reg) == ST_ED_AWAKE |->
    $past(idle_cnt_reg) > $past(sleep_idle_reg))
    else $error("slept before go-sleep time");
  pulse_width_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    $rose(LINK_PULSE_O) && state_reg != ST_NORMAL |-> LINK_PULSE_O[*2] ##1 !LINK_PULSE_O)
    else $error("link pulse width wrong");
  port_pd_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    port_pd[0] |=> !PHY_PWR_EN_O[0])
    else $error("port not powered down");

  sleep_c: cover property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    state_reg == ST_ED_AWAKE ##1 state_reg == ST_ED_SLEEP);
  softwake_c: cover property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I) wake_rst);
  pulse_c: cover property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I) $rose(LINK_PULSE_O));
  lpi_c: cover property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    TX_ASSERT_LPI_O[0] && !RX_CLK_GATE_O[0]);
endmodule
`default_nettype wire

// *** verif/cable_partner_model.sv ***
// far-side cable link partner model for the power mode manager bench
`timescale 1ns/1ps
`default_nettype none
module cable_partner_model #(
  parameter int NUM_PORTS = 3,
  parameter int RESP_DELAY = 1
) (
  // clock
  input wire logic clk_i,
  // scenario controls
  input wire logic plugged_i,
  input wire logic advertise_i,
  input wire logic [NUM_PORTS-1:0] lpi_i,
  // cable side
  output logic [NUM_PORTS-1:0] energy_o,
  output logic [NUM_PORTS-1:0] eee_ok_o,
  output logic [NUM_PORTS-1:0] rx_lpi_o
);
  // ****************
  // cable presence
  // ****************
  // energy shows up a few cycles after plugging, so wake-up is not instant
  logic [RESP_DELAY:0] plug_line = '0;
  always_ff @(posedge clk_i) begin
    plug_line <= {plug_line[RESP_DELAY-1:0], plugged_i};
  end
  assign energy_o = {NUM_PORTS{plug_line[RESP_DELAY-1]}};
  // ****************
  // eee signalling
  // ****************
  // an unplugged cable carries no capability and no idle indication
  always_ff @(posedge clk_i) begin
    eee_ok_o <= {NUM_PORTS{plugged_i & advertise_i}};
    rx_lpi_o <= (plugged_i & advertise_i) ? lpi_i : '0;
  end
endmodule
`default_nettype wire

// *** verif/switch_power_mode_manager_tb.sv ***
// self-checking bench for the switch power mode manager
`timescale 1ns/1ps
`default_nettype none
module switch_power_mode_manager_tb;
  // ****************
  // signals
  // ****************
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [47:0] phy_ctl = 48'h0;
  logic [2:0] tx_req = 3'h0;
  logic [2:0] far_lpi = 3'h0;
  logic plugged = 1'b1;
  logic adv = 1'b0;
  logic [7:0] rdata;
  logic [7:0] rv;
  logic ready, pll_en, mac_en, host_en, int_rst, pkt_en, pulse;
  logic [2:0] energy, eee_ok, rx_ind, pwr_en, ed_en, tx_lpi, mac_tx, tx_gate, rx_gate;
  int mismatches = 0;
  int comparisons = 0;
  logic [7:0] offs [6] = '{8'h0E, 8'h0F, 8'h1D, 8'h2D, 8'h3D, 8'h10};
  logic [7:0] rstv [6] = '{8'h00, 8'h50, 8'h00, 8'h00, 8'h00, 8'h00};
  always #50 clk = ~clk;
  // ****************
  // instances
  // ****************
  // short pulse period and sleep unit keep the run small
  switch_power_mode_manager #(.NUM_PORTS(3), .PULSE_PERIOD(50), .SLEEP_UNIT(4))
    switch_power_mode_manager_inst (.CORE_CLK_I(clk), .SYS_RST_I(rst), .REG_WR_I(wr),
    .REG_RD_I(rd), .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata),
    .REG_READY_O(ready), .CABLE_ENERGY_I(energy), .PHY_BASIC_CONTROL_I(phy_ctl),
    .EEE_OK_I(eee_ok), .TX_LPI_REQ_I(tx_req), .RX_LPI_IND_I(rx_ind), .PLL_EN_O(pll_en),
    .MAC_EN_O(mac_en), .HOST_IF_EN_O(host_en), .INT_RST_O(int_rst), .PACKET_EN_O(pkt_en),
    .LINK_PULSE_O(pulse), .PHY_PWR_EN_O(pwr_en), .PHY_RX_ED_EN_O(ed_en),
    .TX_ASSERT_LPI_O(tx_lpi), .MAC_TX_EN_O(mac_tx), .TX_CLK_GATE_O(tx_gate),
    .RX_CLK_GATE_O(rx_gate));
  cable_partner_model #(.NUM_PORTS(3), .RESP_DELAY(2)) cable_partner_model_inst (
    .clk_i(clk), .plugged_i(plugged), .advertise_i(adv), .lpi_i(far_lpi),
    .energy_o(energy), .eee_ok_o(eee_ok), .rx_lpi_o(rx_ind));
  // ****************
  // tasks
  // ****************
  task automatic close_out;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t value 0x%0h expected 0x%0h", $time, got, exp);
    end
  endtask
  task automatic chk_sig(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    cyc(1);
    wr = 1'b1;
    addr = a;
    wdata = d;
    cyc(1);
    wr = 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    cyc(1);
    rd = 1'b1;
    addr = a;
    cyc(1);
    rd = 1'b0;
    rv = rdata;
  endtask
  task automatic wait_on(input int sel, input logic val, input int bound);
    logic s;
    for (int n = 0; n <= bound; n++) begin
      case (sel)
        0: s = pll_en;
        1: s = pulse;
        2: s = int_rst;
        default: s = mac_tx[0];
      endcase
      if (s === val) begin
        return;
      end
      cyc(1);
    end
    mismatches++;
    $display("[ERR] %0t wait %0d ran out", $time, sel);
    close_out;
  endtask
  task automatic check_defaults;
    foreach (offs[i]) begin
      rd_reg(offs[i]);
      chk_reg(rv, rstv[i]);
    end
  endtask
  // ****************
  // sequence
  // ****************
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    $display("[ERR] %0t run did not finish", $time);
    close_out;
  end
  initial begin
    cyc(2);
    rst = 1'b0;
    check_defaults;
    chk_reg({pll_en, mac_en, host_en, ready, pkt_en, pwr_en}, 8'hFF);
    // reserved code keeps the mode, other bits still land
    wr_reg(pwr_mgr_pkg::OFF_POWER_MODE_CONTROL, 8'h1A);
    rd_reg(pwr_mgr_pkg::OFF_POWER_MODE_CONTROL);
    chk_reg(rv, 8'h02);
    chk_reg({pll_en, mac_en, host_en, ready, pkt_en, pwr_en}, 8'hFF);
    wr_reg(pwr_mgr_pkg::OFF_POWER_MODE_CONTROL, 8'h00);
    // port power-down by register and by phy control word
    for (int i = 0; i < 3; i++) begin
      wr_reg(offs[i+2], 8'h08);
      cyc(2);
      chk_reg({5'h00, pwr_en}, 8'h07 ^ (8'h01 << i));
      rd_reg(offs[i+2]);
      chk_reg(rv, 8'h08);
      wr_reg(offs[i+2], 8'h00);
      phy_ctl[16*i+11] = 1'b1;
      cyc(2);
      chk_reg({5'h00, pwr_en}, 8'h07 ^ (8'h01 << i));
      phy_ctl[16*i+11] = 1'b0;
      cyc(2);
      chk_reg({5'h00, pwr_en}, 8'h07);
    end
    // low power idle on port 0, each direction on its own
    tx_req = 3'h1;
    cyc(3);
    chk_reg({4'h0, tx_lpi[0], mac_tx[0], tx_gate[0], rx_gate[0]}, 8'h04);
    adv = 1'b1;
    cyc(3);
    chk_reg({4'h0, tx_lpi[0], mac_tx[0], tx_gate[0], rx_gate[0]}, 8'h0A);
    far_lpi = 3'h1;
    cyc(3);
    chk_reg({4'h0, tx_lpi[0], mac_tx[0], tx_gate[0], rx_gate[0]}, 8'h0B);
    tx_req = 3'h0;
    cyc(2);
    chk_reg({4'h0, tx_lpi[0], mac_tx[0], tx_gate[0], rx_gate[0]}, 8'h01);
    wait_on(3, 1'b1, 12);
    far_lpi = 3'h0;
    cyc(3);
    chk_reg({4'h0, tx_lpi[0], mac_tx[0], tx_gate[0], rx_gate[0]}, 8'h04);
    chk_reg({5'h00, pwr_en}, 8'h07);
    adv = 1'b0;
    // energy detect: sleep on a quiet cable, pulses, wake on energy
    plugged = 1'b0;
    wr_reg(pwr_mgr_pkg::OFF_SLEEP_IDLE_TIMEOUT, 8'h02);
    wr_reg(pwr_mgr_pkg::OFF_POWER_MODE_CONTROL, 8'h08);
    cyc(6);
    chk_sig(pll_en, 1'b1);
    wait_on(0, 1'b0, 40);
    chk_reg({3'h0, pll_en, mac_en, host_en, ready, pkt_en}, 8'h00);
    chk_reg({5'h00, ed_en}, 8'h07);
    wr_reg(pwr_mgr_pkg::OFF_SLEEP_IDLE_TIMEOUT, 8'h44);
    wait_on(1, 1'b1, 60);
    cyc(1);
    chk_sig(pulse, 1'b1);
    cyc(1);
    chk_sig(pulse, 1'b0);
    plugged = 1'b1;
    wait_on(0, 1'b1, 6);
    chk_reg({pll_en, mac_en, host_en, ready, pkt_en, pwr_en}, 8'hFF);
    rd_reg(pwr_mgr_pkg::OFF_SLEEP_IDLE_TIMEOUT);
    chk_reg(rv, 8'h02);
    wr_reg(pwr_mgr_pkg::OFF_POWER_MODE_CONTROL, 8'h00);
    // soft power-down, then a dummy read wakes and resets
    wr_reg(pwr_mgr_pkg::OFF_SLEEP_IDLE_TIMEOUT, 8'h33);
    wr_reg(pwr_mgr_pkg::OFF_POWER_MODE_CONTROL, 8'h10);
    cyc(3);
    chk_reg({pll_en, mac_en, host_en, ready, pkt_en, pwr_en}, 8'h00);
    chk_reg({5'h00, ed_en}, 8'h00);
    rd_reg(pwr_mgr_pkg::OFF_POWER_MODE_CONTROL);
    wait_on(2, 1'b1, 3);
    cyc(1);
    chk_sig(int_rst, 1'b0);
    wait_on(0, 1'b1, 3);
    check_defaults;
    close_out;
  end
endmodule
`default_nettype wire
